/* File: spr_pkg.sv */
`default_nettype none

package spr_pkg;

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [3:0] OFS_PORT_ONE = 4'h0;
	localparam logic [3:0] OFS_PORT_TWO = 4'h1;
	localparam logic [3:0] OFS_SRG_ONE = 4'h2;
	localparam logic [3:0] OFS_SRG_TWO = 4'h3;
	localparam logic [3:0] OFS_PIN_CTL = 4'h4;
	localparam logic [3:0] OFS_TX_DATA = 4'h5;
	localparam logic [3:0] OFS_STATUS = 4'h6;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_LOOPBACK = 15;
	localparam int BIT_RX_RESET_N = 0;
	localparam int BIT_FS_RESET_N = 7;
	localparam int BIT_GEN_RESET_N = 6;
	localparam int BIT_TX_RESET_N = 0;
	localparam int BIT_GEN_SYNC = 15;
	localparam int BIT_CLK_SOURCE = 13;
	localparam int FRAME_PERIOD_FIELD_MSB = 11;
	localparam int CLOCK_DIVIDE_FIELD_MSB = 7;
	localparam int BIT_PIN_CLK_MODE = 7;
	localparam int BIT_TX_POL = 1;
	localparam int BIT_RX_POL = 0;

	// ----------------------------------------
	// Reset values and counts
	// ----------------------------------------
	localparam logic [15:0] PORT_ONE_RESET = 16'h0000;
	localparam logic [15:0] PORT_TWO_RESET = 16'h0000;
	localparam logic [15:0] SRG_ONE_RESET = 16'h0001;
	localparam logic [15:0] SRG_TWO_RESET = 16'h2000;
	localparam logic [15:0] PIN_CTL_RESET = 16'h0000;
	localparam logic [4:0] TX_LOAD_BITS = 5'h0F;

	typedef enum logic [1:0] {SRC_RESERVED, SRC_LSP, SRC_RX_PIN, SRC_TX_PIN} spr_src_t;
	typedef enum logic [1:0] {GEN_DEVRESET, GEN_HELD, GEN_RUN} spr_gen_t;

endpackage : spr_pkg

`default_nettype wire

/* File: spr_rate_gen.sv */
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module spr_rate_gen (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [spr_pkg::ADDR_W-1:0] regAddr,
	input wire logic [spr_pkg::DATA_W-1:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [spr_pkg::DATA_W-1:0] regReadData,
	input wire logic receiveClockPin,
	input wire logic transmitClockPin,
	input wire logic receiveFrameSync,
	input wire logic receiveDataPin,
	output logic generatedBitClock,
	output logic generatedFramePulse,
	output logic transmitBitClock,
	output logic transmitFrameSync,
	output logic transmitDataPin,
	output logic transmitReadyEvent,
	output logic receiveDataInt,
	output logic receiveFrameInt,
	output logic receiveClockInt,
	output logic receiverEnable
);
	import spr_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] portOne;
		logic [15:0] portTwo;
		logic [15:0] srgOne;
		logic [15:0] srgTwo;
		logic [15:0] pinCtl;
		logic [15:0] txHold;
		logic txFull;
		logic [15:0] txShift;
		logic [4:0] txBits;
		spr_gen_t gen;
		logic [7:0] divCnt;
		logic [11:0] fperCnt;
		logic fsMeta;
		logic fsSync;
		logic fsPrev;
		logic rxClkPrev;
		logic txClkPrev;
		logic bitClk;
		logic framePulse;
		logic txReady;
		logic txData;
		logic rxData;
		logic rxFrame;
		logic rxClk;
		logic rxEnable;
		logic [15:0] rdata;
	} spr_state_t;

	localparam spr_state_t ST_INIT = '{
		portOne: PORT_ONE_RESET,
		portTwo: PORT_TWO_RESET,
		srgOne: SRG_ONE_RESET,
		srgTwo: SRG_TWO_RESET,
		pinCtl: PIN_CTL_RESET,
		gen: GEN_DEVRESET,
		default: '0
	};

	spr_state_t st;
	spr_state_t next_st;

	logic [7:0] divN;
	logic [7:0] hiFrom;
	logic [11:0] frame_period_field;
	logic frame_sync_reset_n;
	logic transmitter_reset_n;
	logic fsEdge;
	logic syncActive;
	logic srcTick;
	logic genRise;
	spr_src_t srcSel;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic regHit(input logic strobe, input logic [3:0] a, input logic [3:0] ofs);
		return strobe && (a == ofs);
	endfunction : regHit

	function automatic logic [15:0] readWord(input logic [3:0] a, input spr_state_t s, input logic sync);
		case (a)
			OFS_PORT_ONE: readWord = s.portOne;
			OFS_PORT_TWO: readWord = s.portTwo;
			OFS_SRG_ONE: readWord = s.srgOne;
			OFS_SRG_TWO: readWord = s.srgTwo;
			OFS_PIN_CTL: readWord = s.pinCtl;
			OFS_TX_DATA: readWord = s.txHold;
			OFS_STATUS: readWord = {11'h000, sync, s.txFull, s.txReady, s.framePulse, s.bitClk};
			default: readWord = 16'h0000;
		endcase
	endfunction : readWord

	assign divN = st.srgOne[CLOCK_DIVIDE_FIELD_MSB:0];
	// Odd divides keep the extra input cycle in the high phase
	assign hiFrom = divN - {1'b0, divN[7:1]};
	assign frame_period_field = st.srgTwo[FRAME_PERIOD_FIELD_MSB:0];
	assign frame_sync_reset_n = st.portTwo[BIT_FS_RESET_N];
	assign transmitter_reset_n = st.portTwo[BIT_TX_RESET_N];
	assign fsEdge = st.fsSync & ~st.fsPrev;
	assign srcSel = spr_src_t'({st.pinCtl[BIT_PIN_CLK_MODE], st.srgTwo[BIT_CLK_SOURCE]});
	assign syncActive = st.srgTwo[BIT_GEN_SYNC] & st.pinCtl[BIT_PIN_CLK_MODE];

	// ----------------------------------------
	// Input clock selection
	// ----------------------------------------
	// Pins are sampled on the system clock, so each pin edge of the selected polarity becomes one tick
	always_comb begin
		case (srcSel)
			SRC_LSP: srcTick = 1'b1;
			SRC_RX_PIN: srcTick = st.pinCtl[BIT_RX_POL] ? (receiveClockPin & ~st.rxClkPrev)
				: (~receiveClockPin & st.rxClkPrev);
			SRC_TX_PIN: srcTick = st.pinCtl[BIT_TX_POL] ? (~transmitClockPin & st.txClkPrev)
				: (transmitClockPin & ~st.txClkPrev);
			default: srcTick = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		genRise = 1'b0;

		next_st.fsMeta = receiveFrameSync;
		next_st.fsSync = st.fsMeta;
		next_st.fsPrev = st.fsSync;
		next_st.rxClkPrev = receiveClockPin;
		next_st.txClkPrev = transmitClockPin;

		if (regHit(regWrite, regAddr, OFS_PORT_ONE)) begin
			next_st.portOne = regWriteData;
		end
		if (regHit(regWrite, regAddr, OFS_PORT_TWO)) begin
			next_st.portTwo = regWriteData;
			next_st.gen = regWriteData[BIT_GEN_RESET_N] ? GEN_RUN : GEN_HELD;
		end
		if (regHit(regWrite, regAddr, OFS_SRG_ONE)) begin
			next_st.srgOne = regWriteData;
		end
		if (regHit(regWrite, regAddr, OFS_SRG_TWO)) begin
			next_st.srgTwo = regWriteData;
		end
		if (regHit(regWrite, regAddr, OFS_PIN_CTL)) begin
			next_st.pinCtl = regWriteData;
		end
		next_st.rdata = regRead ? readWord(regAddr, st, syncActive) : 16'h0000;

		// Bit clock
		case (st.gen)
			GEN_DEVRESET: begin
				next_st.bitClk = ~st.bitClk;
				next_st.divCnt = 8'h00;
			end
			GEN_HELD: begin
				next_st.bitClk = 1'b0;
				next_st.divCnt = 8'h00;
			end
			GEN_RUN: begin
				if (divN == 8'h00) begin
					// Divide by one can only follow the input at tick rate
					if (syncActive && fsEdge) begin
						next_st.bitClk = 1'b1;
					end else if (srcTick) begin
						next_st.bitClk = ~st.bitClk;
					end
				end else begin
					if (syncActive && fsEdge) begin
						next_st.divCnt = divN;
					end else if (srcTick) begin
						if (st.divCnt == 8'h00) begin
							next_st.divCnt = divN;
						end else begin
							next_st.divCnt = st.divCnt - 8'h01;
						end
					end
					next_st.bitClk = next_st.divCnt >= hiFrom;
				end
				genRise = next_st.bitClk & ~st.bitClk;
			end
			default: begin
				next_st.gen = GEN_DEVRESET;
			end
		endcase

		// Frame pulse
		if (!frame_sync_reset_n || st.gen != GEN_RUN) begin
			next_st.framePulse = 1'b0;
			next_st.fperCnt = frame_period_field;
		end else if (syncActive) begin
			if (fsEdge) begin
				next_st.framePulse = 1'b1;
			end else if (genRise) begin
				next_st.framePulse = 1'b0;
			end
		end else if (genRise) begin
			if (st.fperCnt == 12'h000) begin
				next_st.framePulse = 1'b1;
				next_st.fperCnt = frame_period_field;
			end else begin
				next_st.framePulse = 1'b0;
				next_st.fperCnt = st.fperCnt - 12'h001;
			end
		end

		// Transmitter
		if (!transmitter_reset_n) begin
			next_st.txFull = 1'b0;
			next_st.txShift = 16'h0000;
			next_st.txBits = 5'h00;
			next_st.txData = 1'b0;
		end else begin
			if (genRise) begin
				if (next_st.framePulse && !st.framePulse && st.txFull) begin
					next_st.txData = st.txHold[15];
					next_st.txShift = {st.txHold[14:0], 1'b0};
					next_st.txBits = TX_LOAD_BITS;
					next_st.txFull = 1'b0;
				end else if (st.txBits != 5'h00) begin
					next_st.txData = st.txShift[15];
					next_st.txShift = {st.txShift[14:0], 1'b0};
					next_st.txBits = st.txBits - 5'h01;
				end else begin
					next_st.txData = 1'b0;
				end
			end
			// A write in the load cycle still marks the holding word full
			if (regHit(regWrite, regAddr, OFS_TX_DATA)) begin
				next_st.txHold = regWriteData;
				next_st.txFull = 1'b1;
			end
		end
		// Level, not pulse: an edge-triggered consumer must be armed before release
		next_st.txReady = transmitter_reset_n & ~st.txFull;

		// Receive side
		if (st.portOne[BIT_LOOPBACK]) begin
			next_st.rxData = st.txData;
			next_st.rxFrame = st.framePulse;
			next_st.rxClk = st.bitClk;
		end else begin
			next_st.rxData = receiveDataPin;
			next_st.rxFrame = st.fsSync;
			next_st.rxClk = receiveClockPin;
		end
		next_st.rxEnable = st.portOne[BIT_RX_RESET_N];
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st <= ST_INIT;
		end else begin
			st <= next_st;
		end
	end

	assign regReadData = st.rdata;
	assign generatedBitClock = st.bitClk;
	assign generatedFramePulse = st.framePulse;
	assign transmitBitClock = st.bitClk;
	assign transmitFrameSync = st.framePulse;
	assign transmitDataPin = st.txData;
	assign transmitReadyEvent = st.txReady;
	assign receiveDataInt = st.rxData;
	assign receiveFrameInt = st.rxFrame;
	assign receiveClockInt = st.rxClk;
	assign receiverEnable = st.rxEnable;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	a_sync_pin_only: assert property (
		srcSel == SRC_LSP && st.gen == GEN_RUN && divN != 8'h00 && st.divCnt != 8'h00
		|=> st.divCnt == $past(st.divCnt) - 8'h01)
		else $error("divider realigned while fed by peripheral clock");

	a_free_frame: assert property (
		st.gen == GEN_RUN && frame_sync_reset_n && !syncActive && genRise && st.fperCnt == 12'h000
		|=> generatedFramePulse && st.fperCnt == $past(frame_period_field))
		else $error("free running frame pulse missed");

	a_resync_align: assert property (
		syncActive && fsEdge && st.gen == GEN_RUN && divN != 8'h00
		|=> generatedBitClock && st.divCnt == $past(divN))
		else $error("bit clock not realigned on frame sync");

	a_sync_frame_cause: assert property (
		$rose(generatedFramePulse) && $past(syncActive) |-> $past(fsEdge))
		else $error("frame pulse without receive frame sync");

	a_src_reserved: assert property (
		srcSel == SRC_RESERVED |-> !srcTick)
		else $error("reserved clock source produced a tick");

	a_rx_falling: assert property (
		srcSel == SRC_RX_PIN && !st.pinCtl[BIT_RX_POL]
		|-> srcTick == (!receiveClockPin && st.rxClkPrev))
		else $error("receive pin edge polarity wrong");

	a_tx_rising: assert property (
		srcSel == SRC_TX_PIN && !st.pinCtl[BIT_TX_POL]
		|-> srcTick == (transmitClockPin && !st.txClkPrev))
		else $error("transmit pin edge polarity wrong");

	a_frame_quiet: assert property (
		!frame_sync_reset_n |=> !generatedFramePulse ##1 !generatedFramePulse || frame_sync_reset_n)
		else $error("frame pulse while frame logic in reset");

	a_frame_load: assert property (
		!frame_sync_reset_n |=> st.fperCnt == $past(frame_period_field))
		else $error("frame counter not loaded");

	// The edge that releases reset still loads the reset state, so that attempt has nothing to toggle
	a_devreset_div2: assert property (
		!reset && st.gen == GEN_DEVRESET
		|=> generatedBitClock != $past(generatedBitClock) && !generatedFramePulse)
		else $error("bit clock not halved system clock after reset");

	a_held_low: assert property (
		st.gen == GEN_HELD |=> !generatedBitClock && !generatedFramePulse)
		else $error("generator outputs active while held");

	a_tx_disabled: assert property (
		!transmitter_reset_n |=> !transmitReadyEvent && !transmitDataPin)
		else $error("transmitter active while in reset");

	a_tx_ready: assert property (
		$rose(transmitter_reset_n) |=> transmitReadyEvent)
		else $error("transmit ready missing after release");

	a_loop_data: assert property (
		st.portOne[BIT_LOOPBACK] |=> receiveDataInt == $past(transmitDataPin)
			&& receiveClockInt == $past(generatedBitClock))
		else $error("loopback path broken");

endmodule : spr_rate_gen

`default_nettype wire

/* File: spr_peer.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Far-side serial peer: clocks move only on request
// ----------------------------------------
module spr_peer (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic rxStep,
	input wire logic txStep,
	input wire logic fsReq,
	output logic receiveClockPin,
	output logic transmitClockPin,
	output logic receiveFrameSync,
	output logic receiveDataPin
);
	logic fsHold;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			receiveClockPin <= 1'b0;
			transmitClockPin <= 1'b0;
			receiveFrameSync <= 1'b0;
			receiveDataPin <= 1'b0;
			fsHold <= 1'b0;
		end else begin
			if (rxStep) begin
				receiveClockPin <= ~receiveClockPin;
			end
			if (txStep) begin
				transmitClockPin <= ~transmitClockPin;
			end
			// Two cycles wide so the synchroniser cannot miss it
			fsHold <= fsReq;
			receiveFrameSync <= fsReq | fsHold;
			// No valid data here; a toggling line keeps a stale bit from passing
			receiveDataPin <= ~receiveDataPin;
		end
	end
endmodule : spr_peer

`default_nettype wire

/* File: spr_rate_gen_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module spr_rate_gen_bench;
	import spr_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [ADDR_W-1:0] regAddr = 4'h0;
	logic [DATA_W-1:0] regWriteData = 16'h0000;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic rxStep = 1'b0;
	logic txStep = 1'b0;
	logic fsReq = 1'b0;
	logic [DATA_W-1:0] regReadData;
	logic rxPin, txPin, rxFs, rxData, bitClk, frame, txClk, txFs, txData, ready, rdInt, rfInt, rcInt, rxEn;
	int failures = 0;
	int total_checks = 0;
	int n;

	always #5 clk_sys = ~clk_sys;

	spr_rate_gen DUT (.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr), .regWriteData(regWriteData),
		.regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .receiveClockPin(rxPin),
		.transmitClockPin(txPin), .receiveFrameSync(rxFs), .receiveDataPin(rxData),
		.generatedBitClock(bitClk), .generatedFramePulse(frame), .transmitBitClock(txClk),
		.transmitFrameSync(txFs), .transmitDataPin(txData), .transmitReadyEvent(ready),
		.receiveDataInt(rdInt), .receiveFrameInt(rfInt), .receiveClockInt(rcInt), .receiverEnable(rxEn));

	spr_peer PEER (.clk_sys(clk_sys), .reset(reset), .rxStep(rxStep), .txStep(txStep), .fsReq(fsReq),
		.receiveClockPin(rxPin), .transmitClockPin(txPin), .receiveFrameSync(rxFs), .receiveDataPin(rxData));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic summarize;
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic tmo;
		chk(16'h0000, 16'h0001);
		summarize();
	endtask : tmo

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask : cyc

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1 chk(regReadData, exp);
	endtask : rd

	task automatic step(input bit tx);
		@(posedge clk_sys);
		if (tx) begin
			txStep <= 1'b1;
		end else begin
			rxStep <= 1'b1;
		end
		@(posedge clk_sys);
		txStep <= 1'b0;
		rxStep <= 1'b0;
		cyc(5);
	endtask : step

	// Cycles from one rise of the chosen output to the next
	task automatic gap(input bit useFrame, output int g);
		logic p, c;
		int rises;
		rises = 0;
		g = 0;
		#1 p = useFrame ? frame : bitClk;
		for (int k = 0; k < 400; k++) begin
			@(posedge clk_sys);
			#1 c = useFrame ? frame : bitClk;
			if (rises == 1) g++;
			if (c && !p) rises++;
			p = c;
			if (rises == 2) return;
		end
		tmo();
	endtask : gap

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		logic p;
		for (int k = 0; k < 4; k++) begin
			p = bitClk;
			cyc(1);
			chk(16'(bitClk), 16'(!p));
			chk(16'(frame), 16'h0000);
		end
		rd(OFS_PORT_ONE, PORT_ONE_RESET);
		rd(OFS_PORT_TWO, PORT_TWO_RESET);
		rd(OFS_SRG_ONE, SRG_ONE_RESET);
		rd(OFS_SRG_TWO, SRG_TWO_RESET);
		rd(OFS_PIN_CTL, PIN_CTL_RESET);
		wr(4'h7, 16'hFFFF);
		rd(4'h7, 16'h0000);
	endtask : t_reset

	task automatic t_free;
		int rises;
		logic p;
		wr(OFS_SRG_ONE, 16'h0002);
		wr(OFS_SRG_TWO, 16'h2002);
		wr(OFS_PORT_TWO, 16'h0040);
		for (int k = 0; k < 40; k++) begin
			cyc(1);
			chk(16'(frame), 16'h0000);
		end
		wr(OFS_PORT_TWO, 16'h0080);
		for (int k = 0; k < 12; k++) begin
			cyc(1);
			chk(16'({bitClk, frame}), 16'h0000);
		end
		wr(OFS_PORT_TWO, 16'h00C0);
		rises = 0;
		p = 1'b0;
		for (int k = 0; k < 60 && !frame; k++) begin
			cyc(1);
			if (bitClk && !p) rises++;
			p = bitClk;
		end
		chk(16'(rises), 16'h0003);
		gap(1'b1, n);
		chk(16'(n), 16'h0009);
		gap(1'b0, n);
		chk(16'(n), 16'h0003);
	endtask : t_free

	task automatic t_pins;
		logic b, up;
		logic [15:0] pol;
		wr(OFS_SRG_ONE, 16'h0000);
		wr(OFS_PORT_TWO, 16'h0040);
		for (int i = 0; i < 4; i++) begin
			// Polarity bit of whichever pin feeds the generator
			pol = i[0] ? (i[1] ? 16'h0002 : 16'h0001) : 16'h0000;
			wr(OFS_PIN_CTL, 16'h0080 | pol);
			wr(OFS_SRG_TWO, i[1] ? 16'h2000 : 16'h0000);
			up = i[1] ? !i[0] : i[0];
			cyc(3);
			b = bitClk;
			step(i[1]);
			chk(16'(bitClk != b), 16'(up));
			b = bitClk;
			step(i[1]);
			chk(16'(bitClk != b), 16'(!up));
		end
	endtask : t_pins

	task automatic t_sync;
		wr(OFS_PIN_CTL, 16'h0000);
		wr(OFS_SRG_ONE, 16'h0001);
		wr(OFS_SRG_TWO, 16'hA001);
		wr(OFS_PORT_TWO, 16'h00C0);
		gap(1'b1, n);
		chk(16'(n), 16'h0004);
		wr(OFS_PORT_TWO, 16'h0040);
		wr(OFS_PIN_CTL, 16'h0081);
		wr(OFS_SRG_TWO, 16'h8001);
		wr(OFS_PORT_TWO, 16'h00C0);
		for (int k = 0; k < 16; k++) begin
			step(1'b0);
			chk(16'(frame), 16'h0000);
		end
		for (int k = 0; k < 8 && bitClk; k++) step(1'b0);
		chk(16'(bitClk), 16'h0000);
		@(posedge clk_sys);
		fsReq <= 1'b1;
		@(posedge clk_sys);
		fsReq <= 1'b0;
		for (int k = 0; k < 10 && !frame; k++) cyc(1);
		chk(16'({bitClk, frame}), 16'h0003);
	endtask : t_sync

	task automatic t_tx;
		// Held, configured, then released; ready is checked low before release
		wr(OFS_PORT_TWO, 16'h00C0);
		wr(OFS_TX_DATA, 16'hA5A5);
		rd(OFS_TX_DATA, 16'h0000);
		chk(16'(ready), 16'h0000);
		wr(OFS_PORT_TWO, 16'h00C1);
		cyc(2);
		for (int k = 0; k < 20; k++) begin
			cyc(1);
			chk(16'(ready), 16'h0001);
		end
		wr(OFS_TX_DATA, 16'h5A5A);
		cyc(3);
		chk(16'(ready), 16'h0000);
		// Pins idle in sync mode, so bit clock and frame pulse stay frozen high
		rd(OFS_STATUS, 16'h001B);
		cyc(1);
		chk(regReadData, 16'h0000);
		wr(OFS_PORT_TWO, 16'h00C0);
		cyc(2);
		chk(16'({ready, txData}), 16'h0000);
	endtask : t_tx

	task automatic t_shift;
		logic [15:0] word;
		logic pf;
		int k;
		// Still held in reset: move to the peripheral clock, divide 2, frame every 2 bit clocks
		wr(OFS_PIN_CTL, 16'h0000);
		wr(OFS_SRG_TWO, 16'h2001);
		wr(OFS_PORT_TWO, 16'h00C1);
		pf = 1'b1;
		for (k = 0; k < 40; k++) begin
			cyc(1);
			if (frame && !pf) break;
			pf = frame;
		end
		if (k == 40) tmo();
		// The next frame rise is four cycles on and takes the word just written
		wr(OFS_TX_DATA, 16'hC3A5);
		cyc(2);
		chk(16'({txClk, txFs, txData}), 16'h0007);
		word = {15'h0000, txData};
		for (int b = 0; b < 15; b++) begin
			cyc(2);
			word = {word[14:0], txData};
		end
		chk(word, 16'hC3A5);
		chk(16'(ready), 16'h0001);
		wr(OFS_PORT_TWO, 16'h00C0);
	endtask : t_shift

	task automatic t_loop;
		logic p, q;
		int m;
		wr(OFS_PORT_ONE, 16'h0001);
		cyc(3);
		chk(16'({rxEn, rcInt}), 16'({1'b1, rxPin}));
		wr(OFS_PIN_CTL, 16'h0000);
		wr(OFS_SRG_TWO, 16'h2001);
		wr(OFS_SRG_ONE, 16'h0000);
		wr(OFS_PORT_ONE, 16'h8001);
		cyc(3);
		n = 0;
		m = 0;
		for (int k = 0; k < 8; k++) begin
			p = rcInt;
			q = rfInt;
			cyc(1);
			if (rcInt != p) n++;
			if (rfInt != q) m++;
			chk(16'(rdInt), 16'h0000);
		end
		chk(16'(n), 16'h0008);
		// Frame pulse is two cycles high, two low at divide 1 and period 2
		chk(16'(m), 16'h0004);
		wr(OFS_PORT_ONE, 16'h0000);
		cyc(2);
		chk(16'(rxEn), 16'h0000);
		rd(OFS_PORT_TWO, 16'h00C0);
	endtask : t_loop

	initial begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		t_reset();
		t_free();
		t_pins();
		t_sync();
		t_tx();
		t_shift();
		t_loop();
		summarize();
	end
endmodule : spr_rate_gen_bench

`default_nettype wire
